// ===== dv/paof_periph_model.sv
/*
  model of the peripherals beside the pin override block: timer
  compare outputs and spi data and clock outputs.
  assumes the bench sets timer_on and spi_on just after a clock edge.
*/
`timescale 1ns/100ps
module paof_periph_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] timer_on,
  input  wire logic       spi_on,
  output logic      [3:0] timer_en,
  output logic      [3:0] timer_out,
  output logic            spi_slave_out,
  output logic            spi_master_out,
  output logic            spi_sck_out
);
  // ----
  // pattern state
  // ----
  logic [7:0] cnt_ff;
  logic [7:0] lfsr_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff  <= 8'h00;
      lfsr_ff <= 8'hA5;
    end else begin
      cnt_ff  <= cnt_ff + 8'h01;
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5]};
    end
  end

  // ----
  // outputs
  // ----
  // two count windows and two count bits so the compare pins do not all toggle at one rate
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_en  <= 4'h0;
      timer_out <= 4'h0;
    end else begin
      timer_en  <= timer_on;
      timer_out <= {cnt_ff < 8'h40, cnt_ff[0], cnt_ff[1],
                    cnt_ff > 8'hC0};
    end
  end

  // sck stands still outside transfers; data moves every cycle so a
  // stale value cannot pass for a fresh one
  always_ff @(posedge clk) begin
    if (reset) begin
      spi_sck_out    <= 1'h0;
      spi_master_out <= 1'h0;
      spi_slave_out  <= 1'h0;
    end else begin
      spi_sck_out    <= spi_on & ~spi_sck_out;
      spi_master_out <= lfsr_ff[0];
      spi_slave_out  <= ~lfsr_ff[3];
    end
  end
endmodule : paof_periph_model

// ===== dv/testbench.sv
/*
  self-checking bench for paof_top: per-cycle reference of every pad
  control, corner sweeps, random stimulus and pad path checks.
  assumes paof_periph_model drives the timer and spi outputs.
*/
`timescale 1ns/100ps
`define CMP(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module testbench;
  // ----
  // signals
  // ----
  logic       clk, reset, global_pullup_disable, sleep_clamp;
  logic [7:0] porta_direction, porta_output;
  logic [7:1] portb_direction, portb_output, portb_pad_in;
  logic       lcd_enable, spi_enable, spi_master, pin_change_enable;
  logic [1:0] lcd_duty_select;
  logic [7:1] pin_change_mask, pin_change_source_in;
  logic [3:0] timer_on, timer_en, timer_out;
  logic       spi_slave_out, spi_master_out, spi_sck_out;
  logic [7:0] porta_pullup_on, porta_drive_en, porta_drive_val;
  logic [7:0] porta_input_en, porta_analog_pad_path_en;
  logic [7:1] portb_pullup_on, portb_drive_en, portb_drive_val;
  logic [7:1] portb_input_en;
  logic       spi_miso_in, spi_mosi_in, spi_sck_in;
  integer     seed = 32'hCD80;
  integer     checks = 0;
  integer     mismatches = 0;
  logic [31:0] r;
  logic [7:0] g, e_apu, e_aen, e_aval, e_ain, e_aio;
  logic [7:1] frc, pc, e_bpu, e_ben, e_bval, e_bin;
  logic       rst_q = 1'b0;
  logic       on_q = 1'b0;

  paof_periph_model paof_periph_model_inst (
    .clk, .reset, .timer_on, .spi_on(spi_enable), .timer_en, .timer_out,
    .spi_slave_out, .spi_master_out, .spi_sck_out
  );

  paof_top paof_top_inst (
    .clk, .reset, .global_pullup_disable, .sleep_clamp,
    .porta_direction, .porta_output, .portb_direction, .portb_output,
    .lcd_enable, .lcd_duty_select,
    .timer2_compare_a_en(timer_en[3]), .timer2_compare_a_out(timer_out[3]),
    .timer1_compare_b_en(timer_en[2]), .timer1_compare_b_out(timer_out[2]),
    .timer1_compare_a_en(timer_en[1]), .timer1_compare_a_out(timer_out[1]),
    .timer0_compare_a_en(timer_en[0]), .timer0_compare_a_out(timer_out[0]),
    .spi_enable, .spi_master, .spi_slave_out, .spi_master_out, .spi_sck_out,
    .portb_pad_in, .pin_change_enable, .pin_change_mask,
    .porta_pullup_on, .porta_drive_en, .porta_drive_val, .porta_input_en,
    .porta_analog_pad_path_en, .portb_pullup_on, .portb_drive_en,
    .portb_drive_val, .portb_input_en, .pin_change_source_in,
    .spi_miso_in, .spi_mosi_in, .spi_sck_in
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----
  // reference
  // ----
  function automatic logic [7:0] lcd_gate(input logic en,
                                          input logic [1:0] d);
    lcd_gate = {{4{en}}, en & (d > 2'h2), en & (d > 2'h1),
                en & (d > 2'h0), en};
  endfunction : lcd_gate

  // inputs before the edge give the outputs after it
  always @(posedge clk) begin
    if (on_q) begin
      `CMP(porta_pullup_on, e_apu)
      `CMP(porta_drive_en, e_aen)
      `CMP(porta_drive_val, e_aval)
      `CMP(porta_input_en, e_ain)
      `CMP(porta_analog_pad_path_en, e_aio)
      `CMP(portb_pullup_on, e_bpu)
      `CMP(portb_drive_en, e_ben)
      `CMP(portb_drive_val, e_bval)
      `CMP(portb_input_en, e_bin)
    end
    if (on_q && rst_q) begin
      `CMP(pin_change_source_in, 7'h00)
      `CMP({spi_miso_in, spi_mosi_in, spi_sck_in}, 3'h0)
    end
    on_q   = 1'b1;
    rst_q  = reset;
    g      = lcd_gate(lcd_enable, lcd_duty_select);
    frc    = !spi_enable ? 7'h00 : spi_master ? 7'h04 : 7'h03;
    pc     = {7{pin_change_enable}} & pin_change_mask;
    e_aio  = g;
    e_apu  = ~g & ~porta_direction & porta_output
             & {8{~global_pullup_disable}};
    e_aen  = ~g & porta_direction;
    e_aval = porta_output;
    e_ain  = ~g & {8{~sleep_clamp}};
    e_bpu  = portb_output & (frc | ~portb_direction)
             & {7{~global_pullup_disable}};
    e_ben  = portb_direction & ~frc;
    // spi owns the value of its output pins: slave drives miso, master
    // drives mosi and sck
    e_bval = {timer_en & timer_out | ~timer_en & portb_output[7:4],
              spi_enable & ~spi_master ? spi_slave_out : portb_output[3],
              spi_enable & spi_master ? spi_master_out : portb_output[2],
              spi_enable & spi_master ? spi_sck_out : portb_output[1]};
    e_bin  = pc | {7{~sleep_clamp}};
    if (reset) begin
      {e_apu, e_aen, e_aval, e_ain, e_aio} = 40'h0;
      {e_bpu, e_ben, e_bval, e_bin} = 28'h0;
    end
  end

  // ----
  // tasks
  // ----
  task automatic hold(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic rnd;
    r = $random(seed);
    {global_pullup_disable, sleep_clamp, lcd_enable, spi_enable,
     spi_master, pin_change_enable, lcd_duty_select} = r[7:0];
    {porta_direction, porta_output, timer_on} = r[27:8];
    r = $random(seed);
    {portb_direction, portb_output, pin_change_mask, portb_pad_in} = r[27:0];
  endtask : rnd

  // a one-cycle pad glitch must never reach the outputs
  task automatic pad_case(input logic [7:1] v);
    integer i;
    portb_pad_in = v;
    hold(8);
    `CMP({spi_miso_in, spi_mosi_in, spi_sck_in}, v[3:1])
    portb_pad_in = ~v;
    hold(1);
    portb_pad_in = v;
    for (i = 0; i < 8; i++) begin
      hold(1);
      `CMP(pin_change_source_in, v)
    end
  endtask : pad_case

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ----
  // sequence
  // ----
  initial begin
    integer i;
    reset = 1'b1;
    {global_pullup_disable, sleep_clamp, lcd_enable, spi_enable, spi_master,
     pin_change_enable, lcd_duty_select, porta_direction, porta_output,
     timer_on} = 28'h0;
    {portb_direction, portb_output, pin_change_mask, portb_pad_in} = 28'h0;
    hold(20);
    reset = 1'b0;
    porta_output = 8'hFF;
    for (i = 0; i < 16; i++) begin
      {lcd_enable, lcd_duty_select} = i[2:0];
      porta_direction = {8{i[3]}};
      hold(2);
    end
    $display("test lcd_duty done");
    lcd_enable = 1'b0;
    pin_change_mask = 7'h55;
    for (i = 0; i < 32; i++) begin
      {global_pullup_disable, spi_enable, spi_master} = i[2:0];
      {sleep_clamp, pin_change_enable} = i[1:0];
      portb_direction = {7{i[3]}};
      portb_output = {7{i[4]}};
      porta_direction = {8{i[3]}};
      porta_output = {8{i[4]}};
      timer_on = i[4:1];
      hold(3);
    end
    $display("test port_modes done");
    sleep_clamp = 1'b0;
    pad_case(7'h00);
    pad_case(7'h7F);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      pad_case(r[6:0]);
    end
    $display("test pad_path done");
    repeat (200) begin
      rnd();
      hold(1);
    end
    $display("test random done");
    reset = 1'b1;
    hold(2);
    reset = 1'b0;
    hold(4);
    $display("test mid_reset done");
    stop_test();
  end

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : testbench

// ===== hw/paof_ovr_if.sv
/*
  interface carrying the override signal group of one pin.
  assumes the driver sets every field each cycle.
*/
`timescale 1ns/100ps
interface paof_ovr_if;
  logic pullup_override_enable;
  logic pullup_override_value;
  logic direction_override_enable;
  logic direction_override_value;
  logic value_override_enable;
  logic value_override_value;
  logic input_enable_override_enable;
  logic input_enable_override_value;
  modport src (output pullup_override_enable, pullup_override_value,
               direction_override_enable, direction_override_value,
               value_override_enable, value_override_value,
               input_enable_override_enable,
               input_enable_override_value);
  modport dst (input  pullup_override_enable, pullup_override_value,
               direction_override_enable, direction_override_value,
               value_override_enable, value_override_value,
               input_enable_override_enable,
               input_enable_override_value);
endinterface : paof_ovr_if

// ===== hw/paof_pin_cell.sv
/*
  one pin cell: resolves pull-up, driver, value and input enable from
  the port bits and an override group; registers the pad controls.
  assumes a single clock and synchronous active high reset.
*/
`timescale 1ns/100ps
module paof_pin_cell
  import paof_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   pin_direction_bit,
  input  wire logic   pin_output_value_bit,
  input  wire logic   global_pullup_disable,
  input  wire logic   sleep_clamp,
  paof_ovr_if.dst     ovr,
  output logic        pullup_on_ff,
  output logic        drive_en_ff,
  output logic        drive_val_ff,
  output logic        input_en_ff
);
  logic nxt_pullup_on;
  logic nxt_drive_en;
  logic nxt_drive_val;
  logic nxt_input_en;

  always_comb begin
    nxt_pullup_on = ovr.pullup_override_enable ?
        ovr.pullup_override_value :
        (!pin_direction_bit && pin_output_value_bit &&
         !global_pullup_disable);
    nxt_drive_en = ovr.direction_override_enable ?
        ovr.direction_override_value : pin_direction_bit;
    nxt_drive_val = ovr.value_override_enable ?
        ovr.value_override_value : pin_output_value_bit;
    nxt_input_en = ovr.input_enable_override_enable ?
        ovr.input_enable_override_value : !sleep_clamp;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pullup_on_ff <= PAOF_PIN_RST;
      drive_en_ff  <= PAOF_PIN_RST;
      drive_val_ff <= PAOF_PIN_RST;
      input_en_ff  <= PAOF_PIN_RST;
    end else begin
      pullup_on_ff <= nxt_pullup_on;
      drive_en_ff  <= nxt_drive_en;
      drive_val_ff <= nxt_drive_val;
      input_en_ff  <= nxt_input_en;
    end
  end

  property p_pullup_rule;
    @(posedge clk) disable iff (reset)
      !ovr.pullup_override_enable && global_pullup_disable
      |=> !pullup_on_ff;
  endproperty
  a_pullup_rule: assert property (p_pullup_rule)
    else $error("pull-up on while globally disabled");

  property p_dir_follow;
    @(posedge clk) disable iff (reset)
      !ovr.direction_override_enable
      |=> drive_en_ff == $past(pin_direction_bit);
  endproperty
  a_dir_follow: assert property (p_dir_follow)
    else $error("driver does not follow direction bit");

  property p_die_ovr;
    @(posedge clk) disable iff (reset)
      ovr.input_enable_override_enable
      |=> input_en_ff == $past(ovr.input_enable_override_value);
  endproperty
  a_die_ovr: assert property (p_die_ovr)
    else $error("input enable ignores override");
endmodule : paof_pin_cell

// ===== hw/paof_pkg.sv
/*
  package for the port alternate function override block: pin indexes,
  reset values and encodings shared by the pin cell and the top module.
  assumes nothing of its surroundings.
*/
package paof_pkg;
  localparam int          PAOF_PINS_A      = 8;
  localparam int          PAOF_PINS_B      = 7;
  localparam int          PAOF_PCINT_BASE  = 9;
  localparam int          PAOF_SEG_LO      = 4;
  localparam int          PAOF_MISO_IDX    = 3;
  localparam int          PAOF_MOSI_IDX    = 2;
  localparam int          PAOF_SCK_IDX     = 1;
  localparam int          PAOF_OC_LO       = 4;
  localparam logic [1:0]  PAOF_DUTY_GT0    = 2'h0;
  localparam logic [1:0]  PAOF_DUTY_GT1    = 2'h1;
  localparam logic [1:0]  PAOF_DUTY_GT2    = 2'h2;
  localparam logic        PAOF_PIN_RST     = 1'h0;
  localparam logic [2:0]  PAOF_SYNC_RST    = 3'h0;
endpackage : paof_pkg

// ===== hw/paof_top.sv
/*
  port alternate function override for port a (lcd pins) and port b
  pins 7..1 (timer compare, spi, pin change sources).
  assumes peripherals drive their signals on clk; pad inputs are async.
*/
//
// Behaviour
// - global pull-up disable kills every pull-up
// - port a carries lcd segments and commons
// - lcd enable forces pa7..4 pull, driver, input off
// - pa3..1 gated by lcd enable and duty, pa0 by lcd enable alone
// - pb7..4 present timer compare outputs
// - spi master forces miso to input
// - spi slave forces mosi and sck to input
// - forced spi input keeps pull-up from port bit
// - pb7..1 feed pin change sources 15..9
// - pull-up follows override else port config
// - driver follows override else direction bit
// - input enable follows override else sleep
`timescale 1ns/100ps
module paof_top
  import paof_pkg::*;
#(
  parameter int NA = PAOF_PINS_A,
  parameter int NB = PAOF_PINS_B
)(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          global_pullup_disable,
  input  wire logic          sleep_clamp,
  input  wire logic [NA-1:0] porta_direction,
  input  wire logic [NA-1:0] porta_output,
  input  wire logic [NB:1]   portb_direction,
  input  wire logic [NB:1]   portb_output,
  input  wire logic          lcd_enable,
  input  wire logic [1:0]    lcd_duty_select,
  input  wire logic          timer2_compare_a_en,
  input  wire logic          timer2_compare_a_out,
  input  wire logic          timer1_compare_b_en,
  input  wire logic          timer1_compare_b_out,
  input  wire logic          timer1_compare_a_en,
  input  wire logic          timer1_compare_a_out,
  input  wire logic          timer0_compare_a_en,
  input  wire logic          timer0_compare_a_out,
  input  wire logic          spi_enable,
  input  wire logic          spi_master,
  input  wire logic          spi_slave_out,
  input  wire logic          spi_master_out,
  input  wire logic          spi_sck_out,
  input  wire logic [NB:1]   portb_pad_in,
  input  wire logic          pin_change_enable,
  input  wire logic [NB:1]   pin_change_mask,
  output logic      [NA-1:0] porta_pullup_on,
  output logic      [NA-1:0] porta_drive_en,
  output logic      [NA-1:0] porta_drive_val,
  output logic      [NA-1:0] porta_input_en,
  output logic      [NA-1:0] porta_analog_pad_path_en,
  output logic      [NB:1]   portb_pullup_on,
  output logic      [NB:1]   portb_drive_en,
  output logic      [NB:1]   portb_drive_val,
  output logic      [NB:1]   portb_input_en,
  output logic      [NB:1]   pin_change_source_in,
  output logic               spi_miso_in,
  output logic               spi_mosi_in,
  output logic               spi_sck_in
);
  // ----------------------------------------------------------------
  // port a: lcd overrides
  // ----------------------------------------------------------------
  logic [NA-1:0] lcd_gate;
  logic          spi_m;
  logic          spi_s;
  logic [NB:1]   vo_en;
  logic [NB:1]   vo_val;
  logic [NB:1]   spi_pin;
  logic [NB:1]   sync_a_ff;
  logic [NB:1]   sync_b_ff;
  logic [NB:1]   sync_c_ff;
  logic [NB:1]   in_ff;

  always_comb begin
    for (int i = 0; i < NA; i++) begin
      lcd_gate[i] = lcd_enable;
    end
    lcd_gate[3] = lcd_enable && (lcd_duty_select > PAOF_DUTY_GT2);
    lcd_gate[2] = lcd_enable && (lcd_duty_select > PAOF_DUTY_GT1);
    lcd_gate[1] = lcd_enable && (lcd_duty_select > PAOF_DUTY_GT0);
    lcd_gate[0] = lcd_enable;
  end

  // lcd pins never get a value override, and no digital input to lcd
  genvar ga;
  generate
    for (ga = 0; ga < NA; ga++) begin : g_pa
      paof_ovr_if ovr_a ();
      assign ovr_a.pullup_override_enable       = lcd_gate[ga];
      assign ovr_a.pullup_override_value        = 1'h0;
      assign ovr_a.direction_override_enable    = lcd_gate[ga];
      assign ovr_a.direction_override_value     = 1'h0;
      assign ovr_a.value_override_enable        = 1'h0;
      assign ovr_a.value_override_value         = 1'h0;
      assign ovr_a.input_enable_override_enable = lcd_gate[ga];
      assign ovr_a.input_enable_override_value  = 1'h0;
      paof_pin_cell u_cell (
        .clk                   (clk),
        .reset                 (reset),
        .pin_direction_bit     (porta_direction[ga]),
        .pin_output_value_bit  (porta_output[ga]),
        .global_pullup_disable (global_pullup_disable),
        .sleep_clamp           (sleep_clamp),
        .ovr                   (ovr_a),
        .pullup_on_ff          (porta_pullup_on[ga]),
        .drive_en_ff           (porta_drive_en[ga]),
        .drive_val_ff          (porta_drive_val[ga]),
        .input_en_ff           (porta_input_en[ga])
      );
    end
  endgenerate

  // analog path opens for segment/common lines while lcd owns the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      porta_analog_pad_path_en <= '0;
    end else begin
      porta_analog_pad_path_en <= lcd_gate;
    end
  end

  // ----------------------------------------------------------------
  // port b: timer and spi overrides
  // ----------------------------------------------------------------
  assign spi_m = spi_enable && spi_master;
  assign spi_s = spi_enable && !spi_master;

  always_comb begin
    vo_en   = '0;
    vo_val  = '0;
    spi_pin = '0;
    // timer outputs only reach the pad when direction bit is one
    vo_en[7]  = timer2_compare_a_en;
    vo_val[7] = timer2_compare_a_out;
    vo_en[6]  = timer1_compare_b_en;
    vo_val[6] = timer1_compare_b_out;
    vo_en[5]  = timer1_compare_a_en;
    vo_val[5] = timer1_compare_a_out;
    vo_en[4]  = timer0_compare_a_en;
    vo_val[4] = timer0_compare_a_out;
    spi_pin[PAOF_MISO_IDX] = spi_m;
    spi_pin[PAOF_MOSI_IDX] = spi_s;
    spi_pin[PAOF_SCK_IDX]  = spi_s;
    vo_en[PAOF_MISO_IDX]   = spi_s;
    vo_val[PAOF_MISO_IDX]  = spi_slave_out;
    vo_en[PAOF_MOSI_IDX]   = spi_m;
    vo_val[PAOF_MOSI_IDX]  = spi_master_out;
    vo_en[PAOF_SCK_IDX]    = spi_m;
    vo_val[PAOF_SCK_IDX]   = spi_sck_out;
  end

  genvar gb;
  generate
    for (gb = 1; gb <= NB; gb++) begin : g_pb
      paof_ovr_if ovr_b ();
      // forced input keeps the port bit as pull-up control
      assign ovr_b.pullup_override_enable       = spi_pin[gb];
      assign ovr_b.pullup_override_value        =
          portb_output[gb] && !global_pullup_disable;
      assign ovr_b.direction_override_enable    = spi_pin[gb];
      assign ovr_b.direction_override_value     = 1'h0;
      assign ovr_b.value_override_enable        = vo_en[gb];
      assign ovr_b.value_override_value         = vo_val[gb];
      assign ovr_b.input_enable_override_enable =
          pin_change_enable && pin_change_mask[gb];
      assign ovr_b.input_enable_override_value  = 1'h1;
      paof_pin_cell u_cell (
        .clk                   (clk),
        .reset                 (reset),
        .pin_direction_bit     (portb_direction[gb]),
        .pin_output_value_bit  (portb_output[gb]),
        .global_pullup_disable (global_pullup_disable),
        .sleep_clamp           (sleep_clamp),
        .ovr                   (ovr_b),
        .pullup_on_ff          (portb_pullup_on[gb]),
        .drive_en_ff           (portb_drive_en[gb]),
        .drive_val_ff          (portb_drive_val[gb]),
        .input_en_ff           (portb_input_en[gb])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad input synchroniser and pin change routing
  // ----------------------------------------------------------------
  // a change is taken only when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a_ff <= '0;
      sync_b_ff <= '0;
      sync_c_ff <= '0;
      in_ff     <= '0;
    end else begin
      sync_a_ff <= portb_pad_in;
      sync_b_ff <= sync_a_ff;
      sync_c_ff <= sync_b_ff;
      for (int i = 1; i <= NB; i++) begin
        if (sync_b_ff[i] == sync_c_ff[i]) begin
          in_ff[i] <= sync_c_ff[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_change_source_in <= '0;
      spi_miso_in          <= 1'h0;
      spi_mosi_in          <= 1'h0;
      spi_sck_in           <= 1'h0;
    end else begin
      pin_change_source_in <= in_ff;
      spi_miso_in          <= in_ff[PAOF_MISO_IDX];
      spi_mosi_in          <= in_ff[PAOF_MOSI_IDX];
      spi_sck_in           <= in_ff[PAOF_SCK_IDX];
    end
  end

  property p_lcd_off;
    @(posedge clk) disable iff (reset)
      lcd_enable |=> porta_drive_en[7:4] == 4'h0 &&
                     porta_pullup_on[7:4] == 4'h0 &&
                     porta_input_en[7:4] == 4'h0;
  endproperty
  a_lcd_off: assert property (p_lcd_off)
    else $error("lcd segment pin not released");

  property p_com3;
    @(posedge clk) disable iff (reset)
      lcd_enable && lcd_duty_select == 2'h3 |=> !porta_drive_en[3];
  endproperty
  a_com3: assert property (p_com3)
    else $error("common 3 pin still driven");

  property p_com1_free;
    @(posedge clk) disable iff (reset)
      lcd_duty_select == 2'h0
      |=> porta_drive_en[1] == $past(porta_direction[1]);
  endproperty
  a_com1_free: assert property (p_com1_free)
    else $error("common 1 gated at lowest duty");

  property p_miso_in;
    @(posedge clk) disable iff (reset)
      spi_m |=> !portb_drive_en[3];
  endproperty
  a_miso_in: assert property (p_miso_in)
    else $error("miso driven in master mode");

  property p_sck_in;
    @(posedge clk) disable iff (reset)
      spi_s |=> !portb_drive_en[1] && !portb_drive_en[2];
  endproperty
  a_sck_in: assert property (p_sck_in)
    else $error("mosi or sck driven in slave mode");

  property p_spi_pull;
    @(posedge clk) disable iff (reset)
      spi_s && !global_pullup_disable
      |=> portb_pullup_on[2] == $past(portb_output[2]);
  endproperty
  a_spi_pull: assert property (p_spi_pull)
    else $error("forced input pull-up lost port bit");

  property p_oc_val;
    @(posedge clk) disable iff (reset)
      timer2_compare_a_en
      |=> portb_drive_val[7] == $past(timer2_compare_a_out);
  endproperty
  a_oc_val: assert property (p_oc_val)
    else $error("compare output not on pin 7");

  property p_pcint;
    @(posedge clk) disable iff (reset)
      ##1 1 |=> pin_change_source_in == $past(in_ff);
  endproperty
  a_pcint: assert property (p_pcint)
    else $error("pin change source not routed");
endmodule : paof_top
